// ### src/ds1_line_code.sv
`timescale 1ns/1ps
`include "ds1_line_consts.svh"
// Summary of operation
// - Each one bit sends a pulse, zero none
// - Successive mark pulses alternate in polarity
// - Line code selectable: ZCS or B8ZS
// - ZCS forces bit 1 of zero octet
// - Line code resets to ZCS
// - B8ZS replaces zero octet, violations at 4,1
// - Two same-polarity pulses mean bipolar violation
// - B8ZS decoder restores zero octet, no error
// - Compensation setting holds values 1 to 5
// - Compensation resets to setting 1
// - Timing taken from recovered receive clock
// - Primary source selectable among three interfaces
// - Secondary and tertiary sources back up primary
// - Per source: loop timed or free running
module ds1_line_code (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Configuration
   input wire logic code_sel,
   input wire logic code_load,
   input wire logic [2:0] comp_in,
   input wire logic comp_load,
   input wire logic [1:0] primary_sel,
   input wire logic [2:0] free_run_sel,
   // Transmit octets from framer
   input wire logic tx_valid,
   output logic tx_ready,
   input wire logic [7:0] tx_data,
   // Line bit strobe (one bit per pulse)
   input wire logic line_bit_en,
   // Transmit line pins
   output logic tx_pos,
   output logic tx_neg,
   // Receive line pins
   input wire logic rx_pos,
   input wire logic rx_neg,
   // Receive octets to framer
   output logic rx_valid,
   output logic [7:0] rx_data,
   output logic rx_violation,
   // Sync sources (recovered clock ticks and loss flags of three interfaces)
   input wire logic [2:0] rec_tick,
   input wire logic [2:0] src_lost,
   // Status
   output logic code_mode,
   output logic [2:0] comp_setting,
   output logic [1:0] sync_source,
   output logic sync_loop,
   output logic timing_tick
);
   ////////////////////////////////////////////////////////////////////////
   // Configuration
   logic code_reg; // Line code choice
   logic [2:0] comp_reg; // Cable compensation

   // Line code select, loaded on request
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         code_reg <= `CODE_ZCS;
      end else if (clk_en && code_load) begin
         code_reg <= code_sel;
      end
   end

   // Compensation setting, out-of-range writes ignored
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         comp_reg <= `COMP_RESET;
      end else if (clk_en && comp_load && comp_in >= `COMP_MIN && comp_in <= `COMP_MAX) begin
         comp_reg <= comp_in;
      end
   end

   assign code_mode = code_reg;
   assign comp_setting = comp_reg;

   ////////////////////////////////////////////////////////////////////////
   // Transmit buffer
   logic buf_valid;
   logic buf_ready;
   logic [7:0] buf_data;

   ds1_pair_buffer tx_buffer (
      .clk(clk),
      .rst_n(rst_n),
      .clk_en(clk_en),
      .in_valid(tx_valid),
      .in_ready(tx_ready),
      .in_data(tx_data),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_data)
   );

   ////////////////////////////////////////////////////////////////////////
   // Transmit encoder
   logic [7:0] sh_data_reg; // Octet being sent, MSB first
   logic [7:0] sh_viol_reg; // Marks that repeat the last polarity
   logic [2:0] tx_cnt_reg; // Bit index in octet
   logic sh_busy_reg; // Octet in flight
   logic last_pol_reg; // Polarity of last mark, 1 = positive
   logic [7:0] enc_data;
   logic [7:0] enc_viol;
   logic load_oct;
   logic send_bit;
   logic bit_pol;

   // Next octet taken when idle or on last bit
   assign load_oct = buf_valid && (!sh_busy_reg || (line_bit_en && tx_cnt_reg == `OCTET_LAST));
   assign buf_ready = clk_en && load_oct;
   assign send_bit = clk_en && line_bit_en && sh_busy_reg;

   // Ones-density coding of a zero octet
   always_comb begin
      enc_data = buf_data;
      enc_viol = `OCTET_ZERO;
      if (buf_data == `OCTET_ZERO) begin
         if (code_reg == `CODE_ZCS) begin
            enc_data = `ZCS_FORCE;
         end else begin
            enc_data = `SUB_MARKS;
            enc_viol = `SUB_VIOL;
         end
      end
   end

   // Violation marks repeat last polarity, others alternate
   assign bit_pol = sh_viol_reg[7] ? last_pol_reg : ~last_pol_reg;

   // Shift register and bit counter
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sh_data_reg <= 8'h00;
         sh_viol_reg <= 8'h00;
         tx_cnt_reg <= 3'h0;
         sh_busy_reg <= 1'b0;
      end else if (clk_en) begin
         if (load_oct) begin
            sh_data_reg <= enc_data;
            sh_viol_reg <= enc_viol;
            tx_cnt_reg <= 3'h0;
            sh_busy_reg <= 1'b1;
         end else if (send_bit) begin
            sh_data_reg <= {sh_data_reg[6:0], 1'b0};
            sh_viol_reg <= {sh_viol_reg[6:0], 1'b0};
            tx_cnt_reg <= tx_cnt_reg + 3'h1;
            if (tx_cnt_reg == `OCTET_LAST) begin
               sh_busy_reg <= 1'b0;
            end
         end
      end
   end

   // Line pulses and polarity memory
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_pos <= 1'b0;
         tx_neg <= 1'b0;
         last_pol_reg <= 1'b0;
      end else if (clk_en && line_bit_en) begin
         if (sh_busy_reg && sh_data_reg[7]) begin
            tx_pos <= bit_pol;
            tx_neg <= ~bit_pol;
            last_pol_reg <= bit_pol;
         end else begin
            tx_pos <= 1'b0;
            tx_neg <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive pin synchronisers
   logic [1:0] rx_pos_sync_reg;
   logic [1:0] rx_neg_sync_reg;

   // Two stages before any logic reads the pins
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_pos_sync_reg <= 2'h0;
         rx_neg_sync_reg <= 2'h0;
      end else if (clk_en) begin
         rx_pos_sync_reg <= {rx_pos_sync_reg[0], rx_pos};
         rx_neg_sync_reg <= {rx_neg_sync_reg[0], rx_neg};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Receive decoder
   logic rx_mark;
   logic rx_pol;
   logic rx_bpv;
   logic rx_last_pol_reg; // Polarity of last received mark
   logic [7:0] rx_sh_reg; // Bits collected
   logic [7:0] rx_vsh_reg; // Violations collected
   logic [2:0] rx_cnt_reg;
   logic [7:0] oct_bits;
   logic [7:0] oct_viol;
   logic oct_sub;

   assign rx_mark = rx_pos_sync_reg[1] ^ rx_neg_sync_reg[1];
   assign rx_pol = rx_pos_sync_reg[1];
   // Same polarity as the last mark
   assign rx_bpv = rx_mark && (rx_pol == rx_last_pol_reg);
   assign oct_bits = {rx_sh_reg[6:0], rx_mark};
   assign oct_viol = {rx_vsh_reg[6:0], rx_bpv};
   assign oct_sub = (code_reg == `CODE_B8ZS) && (oct_bits == `SUB_MARKS) && (oct_viol == `SUB_VIOL);

   // Bit sampling with the line strobe
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_last_pol_reg <= 1'b0;
         rx_sh_reg <= 8'h00;
         rx_vsh_reg <= 8'h00;
         rx_cnt_reg <= 3'h0;
      end else if (clk_en && line_bit_en) begin
         rx_sh_reg <= oct_bits;
         rx_vsh_reg <= oct_viol;
         rx_cnt_reg <= rx_cnt_reg + 3'h1;
         if (rx_mark) begin
            rx_last_pol_reg <= rx_pol;
         end
      end
   end

   // Octet output and violation report
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_valid <= 1'b0;
         rx_data <= 8'h00;
         rx_violation <= 1'b0;
      end else if (clk_en) begin
         rx_valid <= line_bit_en && rx_cnt_reg == `OCTET_LAST;
         if (line_bit_en && rx_cnt_reg == `OCTET_LAST) begin
            rx_data <= oct_sub ? `OCTET_ZERO : oct_bits;
            rx_violation <= !oct_sub && (oct_viol != `OCTET_ZERO);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sync source selection
   ds1_line_pkg::sync_state_type sync_state_reg;
   logic [1:0] prim_reg; // Primary interface number
   logic [1:0] sec_num;
   logic [1:0] ter_num;
   logic [1:0] active_num;

   // Primary choice; illegal code keeps the first interface
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         prim_reg <= `SRC_FIRST;
      end else if (clk_en) begin
         prim_reg <= (primary_sel > `SRC_THIRD) ? `SRC_FIRST : primary_sel;
      end
   end

   // Backups are the second then third, the first standing in for the primary
   assign sec_num = (prim_reg == `SRC_SECOND) ? `SRC_FIRST : `SRC_SECOND;
   assign ter_num = (prim_reg == `SRC_THIRD) ? `SRC_FIRST : `SRC_THIRD;

   // Fall down the order on loss, climb back when recovered
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_state_reg <= ds1_line_pkg::SEL_PRIMARY;
      end else if (clk_en) begin
         if (!src_lost[prim_reg]) begin
            sync_state_reg <= ds1_line_pkg::SEL_PRIMARY;
         end else if (!src_lost[sec_num]) begin
            sync_state_reg <= ds1_line_pkg::SEL_SECONDARY;
         end else if (!src_lost[ter_num]) begin
            sync_state_reg <= ds1_line_pkg::SEL_TERTIARY;
         end else begin
            sync_state_reg <= ds1_line_pkg::SEL_HOLDOVER;
         end
      end
   end

   // Active interface number
   always_comb begin
      unique case (sync_state_reg)
         ds1_line_pkg::SEL_PRIMARY: active_num = prim_reg;
         ds1_line_pkg::SEL_SECONDARY: active_num = sec_num;
         ds1_line_pkg::SEL_TERTIARY: active_num = ter_num;
         ds1_line_pkg::SEL_HOLDOVER: active_num = prim_reg;
         default: active_num = prim_reg;
      endcase
   end

   // Timing tick: recovered clock when loop timed, local otherwise
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sync_source <= `SRC_FIRST;
         sync_loop <= 1'b1;
         timing_tick <= 1'b0;
      end else if (clk_en) begin
         sync_source <= active_num;
         sync_loop <= !free_run_sel[active_num] && sync_state_reg != ds1_line_pkg::SEL_HOLDOVER;
         if (free_run_sel[active_num] || sync_state_reg == ds1_line_pkg::SEL_HOLDOVER) begin
            timing_tick <= line_bit_en;
         end else begin
            timing_tick <= rec_tick[active_num];
         end
      end
   end
endmodule

// ### src/ds1_line_consts.svh
`ifndef DS1_LINE_CONSTS_SVH
`define DS1_LINE_CONSTS_SVH

// Line code select values
`define CODE_ZCS 1'b0
`define CODE_B8ZS 1'b1
// Octet width and bit-counter limits
`define OCTET_LAST 3'h7
`define OCTET_ZERO 8'h00
// Forced one for zero code suppression (second least significant bit)
`define ZCS_FORCE 8'h02
// Cable loss compensation settings
`define COMP_MIN 3'h1
`define COMP_MAX 3'h5
`define COMP_RESET 3'h1
// Sync source numbers
`define SRC_FIRST 2'h0
`define SRC_SECOND 2'h1
`define SRC_THIRD 2'h2
// Substitution pattern 000VB0VB: positions that carry a pulse (bit 7 sent first)
`define SUB_MARKS 8'h1b
// Positions that carry a violation
`define SUB_VIOL 8'h12

`endif

// ### src/ds1_line_pkg.sv
package ds1_line_pkg;
   // Timing source chosen by the selector
   typedef enum logic [3:0] {
      SEL_PRIMARY = 4'b0001,
      SEL_SECONDARY = 4'b0010,
      SEL_TERTIARY = 4'b0100,
      SEL_HOLDOVER = 4'b1000
   } sync_state_type;
endpackage

// ### src/ds1_pair_buffer.sv
`timescale 1ns/1ps
// Two-entry buffer: full throughput, no word lost when the sink stalls
module ds1_pair_buffer (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Fill side
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [7:0] in_data,
   // Drain side
   output logic out_valid,
   input wire logic out_ready,
   output logic [7:0] out_data
);
   logic [7:0] mem_reg [0:1]; // Storage
   logic wr_ptr_reg; // Write slot
   logic rd_ptr_reg; // Read slot
   logic [1:0] count_reg; // Occupancy
   logic push;
   logic pop;

   assign in_ready = (count_reg != 2'h2);
   assign out_valid = (count_reg != 2'h0);
   assign out_data = mem_reg[rd_ptr_reg];
   assign push = in_valid && in_ready && clk_en;
   assign pop = out_valid && out_ready && clk_en;

   // Storage write
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_reg[0] <= 8'h00;
         mem_reg[1] <= 8'h00;
      end else if (push) begin
         mem_reg[wr_ptr_reg] <= in_data;
      end
   end

   // Pointers and occupancy
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wr_ptr_reg <= 1'b0;
         rd_ptr_reg <= 1'b0;
         count_reg <= 2'h0;
      end else begin
         if (push) begin
            wr_ptr_reg <= ~wr_ptr_reg;
         end
         if (pop) begin
            rd_ptr_reg <= ~rd_ptr_reg;
         end
         if (push && !pop) begin
            count_reg <= count_reg + 2'h1;
         end else if (pop && !push) begin
            count_reg <= count_reg - 2'h1;
         end
      end
   end
endmodule

// ### testbench/ds1_far_end.sv
`timescale 1ns/1ps
// Far-end facility: sends queued octets as bipolar symbols
module ds1_far_end (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Line strobe and pins
   input wire logic line_bit_en,
   output logic rx_pos,
   output logic rx_neg
);
   logic [9:0] q[$]; // Queued {error, substitution, octet}
   logic [15:0] sym; // Symbols of the octet in flight, first bit on top
   logic [16:0] e; // Encoder result
   logic [2:0] bit_reg; // Strobe count within octet, aligned to reset
   logic pol_reg; // High when last mark was positive
   // Queue one octet, optionally with a forced violation
   task automatic send(input logic [7:0] d, input logic b8, input logic err);
      q.push_back({err, b8, d});
   endtask
   // Bipolar encoding of one octet, returns {last polarity, symbols}
   function automatic logic [16:0] enc(input logic [7:0] d, input logic b8, input logic lp);
      logic [15:0] s;
      logic [7:0] v;
      logic sub;
      sub = d == 8'h00 && b8;
      v = (d == 8'h00 && !b8) ? 8'h02 : d;
      for (int i = 7; i >= 0; i--) begin
         s[2*i +: 2] = 2'h0; // Zero sends no pulse
         if (sub && (i == 4 || i == 1)) begin
            s[2*i +: 2] = lp ? 2'h2 : 2'h1; // Violation repeats polarity
         end else if (v[i] || (sub && (i == 3 || i == 0))) begin
            lp = !lp; // Marks alternate
            s[2*i +: 2] = lp ? 2'h2 : 2'h1;
         end
      end
      return {lp, s};
   endfunction
   // One symbol per strobe; a new octet starts on each octet boundary
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_reg <= 3'h0;
         pol_reg <= 1'h0;
         sym = 16'h0000;
         {rx_pos, rx_neg} <= 2'h0;
      end else if (line_bit_en) begin
         bit_reg <= bit_reg + 3'h1;
         if (bit_reg == 3'h7) begin
            e = {pol_reg, 16'h0000};
            if (q.size() > 0) begin
               e = enc(q[0][7:0], q[0][8], pol_reg ^ q[0][9]); // Error flips polarity once
               void'(q.pop_front());
            end
            pol_reg <= e[16];
            sym = e[15:0];
         end else begin
            sym = sym << 2;
         end
         {rx_pos, rx_neg} <= sym[15:14];
      end
   end
endmodule

// ### testbench/ds1_line_code_chk.sv
`timescale 1ns/1ps
// Port-level checker for the line coder
module ds1_line_code_chk (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic clk_en,
   // Configuration
   input wire logic code_sel,
   input wire logic code_load,
   input wire logic [2:0] comp_in,
   input wire logic comp_load,
   input wire logic [1:0] primary_sel,
   // Line side
   input wire logic line_bit_en,
   input wire logic tx_pos,
   input wire logic tx_neg,
   input wire logic rx_valid,
   input wire logic rx_violation,
   // Sync sources
   input wire logic [2:0] rec_tick,
   input wire logic [2:0] src_lost,
   // Status
   input wire logic code_mode,
   input wire logic [2:0] comp_setting,
   input wire logic [1:0] sync_source,
   input wire logic sync_loop,
   input wire logic timing_tick
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   //////////////////////////////////////////////////
   a_code_load_takes: assert property (clk_en && code_load |=> code_mode == $past(code_sel))
      else $error("code mode not loaded");
   a_comp_good_load: assert property (clk_en && comp_load && comp_in >= 3'h1 && comp_in <= 3'h5
      |=> comp_setting == $past(comp_in)) else $error("compensation not loaded");
   a_comp_bad_kept: assert property (comp_load && (comp_in == 3'h0 || comp_in > 3'h5)
      |=> $stable(comp_setting)) else $error("bad compensation accepted");
   a_comp_in_range: assert property (comp_setting >= 3'h1 && comp_setting <= 3'h5)
      else $error("compensation out of range");
   a_tx_one_polarity: assert property (!(tx_pos && tx_neg)) else $error("both polarities driven");
   a_tx_held_between: assert property (!$past(line_bit_en) && !$past(line_bit_en, 2) && $past(rst_n, 2)
      |-> $stable({tx_pos, tx_neg})) else $error("line output moved without strobe");
   a_rx_octet_spacing: assert property (rx_valid |=> !rx_valid [*8]) else $error("octets too close");
   a_primary_pick: assert property ((clk_en && src_lost == 3'h0 && primary_sel == 2'h2) [*4]
      |-> sync_source == 2'h2) else $error("primary source not taken");
   a_backup_second: assert property ((clk_en && src_lost == 3'h1 && primary_sel == 2'h0) [*4]
      |-> sync_source == 2'h1) else $error("secondary source not taken");
   a_all_lost: assert property ((clk_en && src_lost == 3'h7) [*4] |-> !sync_loop)
      else $error("no holdover with all sources lost");
   a_tick_follows: assert property (sync_loop && $past(sync_loop) && $stable(sync_source) && $past(rst_n)
      && $past(clk_en) |-> timing_tick == $past(rec_tick[sync_source])) else $error("timing tick wrong");
   a_tick_local: assert property (!sync_loop && $past(rst_n) && $past(clk_en)
      |-> timing_tick == $past(line_bit_en)) else $error("local timing tick wrong");
   // Main scenarios reached
   cover property (rx_valid && rx_violation);
   cover property (!sync_loop && src_lost == 3'h7);
   cover property (code_mode && tx_neg);
endmodule

bind ds1_line_code ds1_line_code_chk chk (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .code_sel(code_sel),
   .code_load(code_load), .comp_in(comp_in), .comp_load(comp_load), .primary_sel(primary_sel),
   .line_bit_en(line_bit_en), .tx_pos(tx_pos), .tx_neg(tx_neg), .rx_valid(rx_valid),
   .rx_violation(rx_violation), .rec_tick(rec_tick), .src_lost(src_lost), .code_mode(code_mode),
   .comp_setting(comp_setting), .sync_source(sync_source), .sync_loop(sync_loop), .timing_tick(timing_tick));

// ### testbench/ds1_line_code_tb.sv
`timescale 1ns/1ps
// Self-checking bench for the line coder
module ds1_line_code_tb;
   // Design inputs
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic clk_en = 1'h1;
   logic code_sel = 1'h0;
   logic code_load = 1'h0;
   logic [2:0] comp_in = 3'h0;
   logic comp_load = 1'h0;
   logic [1:0] primary_sel = 2'h0;
   logic [2:0] free_run_sel = 3'h0;
   logic tx_valid = 1'h0;
   logic [7:0] tx_data = 8'h00;
   logic line_bit_en = 1'h0;
   logic [2:0] rec_tick = 3'h0;
   logic [2:0] src_lost = 3'h0;
   // Design outputs and far-end pins
   logic tx_ready, tx_pos, tx_neg, rx_pos, rx_neg, rx_valid, rx_violation, code_mode, sync_loop, timing_tick;
   logic [7:0] rx_data;
   logic [2:0] comp_setting;
   logic [1:0] sync_source;
   // Bench state
   int fail_count = 0;
   int checks_done = 0;
   int cycles = 0;
   logic [31:0] cyc = 32'h0000_0000; // Free cycle count for strobes
   logic last = 1'h0; // Last transmitted mark polarity
   logic [2:0] want = 3'h1;
   logic [1:0] txq[$], expq[$];
   logic [8:0] rxq[$];
   logic [7:0] txo [8] = '{8'ha5, 8'h00, 8'h00, 8'hff, 8'h80, 8'h00, 8'h00, 8'h01};
   logic [7:0] rxo [8] = '{8'h5a, 8'h00, 8'hc3, 8'h3c, 8'h81, 8'h00, 8'h00, 8'ha5};
   ds1_line_code uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .code_sel(code_sel), .code_load(code_load),
      .comp_in(comp_in), .comp_load(comp_load), .primary_sel(primary_sel), .free_run_sel(free_run_sel),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data), .line_bit_en(line_bit_en), .tx_pos(tx_pos),
      .tx_neg(tx_neg), .rx_pos(rx_pos), .rx_neg(rx_neg), .rx_valid(rx_valid), .rx_data(rx_data),
      .rx_violation(rx_violation), .rec_tick(rec_tick), .src_lost(src_lost), .code_mode(code_mode),
      .comp_setting(comp_setting), .sync_source(sync_source), .sync_loop(sync_loop), .timing_tick(timing_tick));
   ds1_far_end far (.clk(clk), .rst_n(rst_n), .line_bit_en(line_bit_en), .rx_pos(rx_pos), .rx_neg(rx_neg));
   //////////////////////////////////////////////////
   initial begin
      forever #5 clk = !clk;
   end
   // Strobe every 8 cycles, staggered recovered ticks
   always @(posedge clk) begin
      #1;
      line_bit_en = cyc[2:0] == 3'h7;
      rec_tick = {cyc[4:0] == 5'h00, cyc[3:0] == 4'h5, cyc[1:0] == 2'h2};
      cyc++;
   end
   // Collect line symbols and octets from the first nonzero one
   always @(negedge clk) begin
      if (rst_n && cyc[2:0] == 3'h3 && (tx_pos || tx_neg || txq.size() > 0)) txq.push_back({tx_pos, tx_neg});
      if (rst_n && rx_valid && (rx_data != 8'h00 || rxq.size() > 0)) rxq.push_back({rx_violation, rx_data});
   end
   // Hang guard
   always @(posedge clk) begin
      cycles++;
      if (cycles == 5000) begin
         fail_count++;
         summarize();
      end
   end
   //////////////////////////////////////////////////
   task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // Offer one octet and hold it until taken
   task automatic push(input logic [7:0] d);
      int n;
      n = 0;
      tx_valid = 1'h1;
      tx_data = d;
      while (tx_ready !== 1'h1 && n < 200) begin
         @(posedge clk);
         #1;
         n++;
      end
      if (n == 200) fail_count++;
      @(posedge clk);
      #1;
   endtask
   task automatic sync_step(input logic [1:0] ps, input logic [2:0] fr, input logic [2:0] lost,
                            input logic [2:0] src, input logic loop);
      primary_sel = ps;
      free_run_sel = fr;
      src_lost = lost;
      repeat (5) @(posedge clk);
      #1;
      if (src != 3'h7) check("sync_source", 9'(sync_source), 9'(src));
      check("sync_loop", 9'(sync_loop), 9'(loop));
   endtask
   // One traffic phase in each direction under one line code
   task automatic phase(input logic b8);
      logic [16:0] e;
      logic [7:0] d;
      code_sel = b8;
      code_load = 1'h1;
      @(posedge clk);
      #1;
      code_load = 1'h0;
      check("code_mode", 9'(code_mode), 9'(b8));
      txq.delete();
      rxq.delete();
      expq.delete();
      for (int i = 0; i < 4; i++) begin
         far.send(rxo[4*b8+i], b8, !b8 && i == 2);
         e = far.enc(txo[4*b8+i], b8, last);
         last = e[16];
         for (int j = 15; j > 0; j -= 2) expq.push_back(e[j -: 2]);
      end
      for (int i = 0; i < 4; i++) push(txo[4*b8+i]);
      tx_valid = 1'h0;
      repeat (450) @(posedge clk);
      #1;
      for (int i = 0; i < 32; i++) check("tx_symbol", 9'(txq[i]), 9'(expq[i]));
      for (int i = 0; i < 4; i++) begin
         d = rxo[4*b8+i];
         check("rx_octet", rxq[i], {!b8 && i == 2, (d == 8'h00 && !b8) ? 8'h02 : d});
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   //////////////////////////////////////////////////
   initial begin
      repeat (20) @(posedge clk);
      #1;
      rst_n = 1'h1;
      @(posedge clk);
      #1;
      check("code_mode", 9'(code_mode), 9'h000);
      check("comp_setting", 9'(comp_setting), 9'h001);
      check("sync_source", 9'(sync_source), 9'h000);
      check("sync_loop", 9'(sync_loop), 9'h001);
      check("tx_ready", 9'(tx_ready), 9'h001);
      // Every compensation code, out-of-range ones ignored
      for (int v = 0; v < 8; v++) begin
         comp_in = 3'(v);
         comp_load = 1'h1;
         @(posedge clk);
         #1;
         comp_load = 1'h0;
         if (v >= 1 && v <= 5) want = 3'(v);
         check("comp_setting", 9'(comp_setting), 9'(want));
      end
      sync_step(2'h2, 3'h0, 3'h0, 3'h2, 1'h1);
      sync_step(2'h2, 3'h4, 3'h0, 3'h2, 1'h0);
      sync_step(2'h2, 3'h0, 3'h6, 3'h0, 1'h1);
      sync_step(2'h2, 3'h0, 3'h5, 3'h1, 1'h1);
      sync_step(2'h2, 3'h0, 3'h7, 3'h7, 1'h0);
      sync_step(2'h1, 3'h0, 3'h2, 3'h0, 1'h1);
      sync_step(2'h0, 3'h0, 3'h1, 3'h1, 1'h1);
      sync_step(2'h0, 3'h0, 3'h0, 3'h0, 1'h1);
      phase(1'h0);
      phase(1'h1);
      summarize();
   end
endmodule
